/* hw/rrf_pkg.sv */
package rrf_pkg;
  // register byte offsets
  localparam logic [7:0] RRF_ADR_FUNC = 8'h00;
  localparam logic [7:0] RRF_ADR_CMD = 8'h04;
  localparam logic [7:0] RRF_ADR_FCFG = 8'h08;
  localparam logic [7:0] RRF_ADR_THR = 8'h0C;
  localparam logic [7:0] RRF_ADR_DCUR = 8'h10;
  localparam logic [7:0] RRF_ADR_STAT = 8'h14;
  localparam logic [7:0] RRF_ADR_READ = 8'h18;
  // field positions
  localparam int RRF_CMD_UP = 0;
  localparam int RRF_CMD_DOWN = 1;
  localparam int RRF_CMD_AUTO = 2;
  localparam int RRF_CMD_AVERAGING_ACTIVE_INDICATOR = 3;
  localparam int RRF_FUNC_RATE_LSB = 8;
  localparam int RRF_FCFG_TYPE_BIT = 8;
  // reset values and limits
  localparam logic [15:0] RRF_THR_RST = 16'h000A;
  localparam logic [15:0] RRF_THR_MIN = 16'h0001;
  localparam logic [15:0] RRF_THR_MAX = 16'h03E8;
  localparam logic [6:0] RRF_FCNT_RST = 7'h0A;
  localparam logic [6:0] RRF_FCNT_MIN = 7'h01;
  localparam logic [6:0] RRF_FCNT_MAX = 7'h64;
  localparam int RRF_NFUNC = 11;
  localparam int RRF_DEPTH = 100;
  // reading scale: nominal full scale count on every range
  localparam logic [23:0] RRF_FS = 24'h0F4240;
  localparam logic [23:0] RRF_UP_LIM = 24'h124F80;
  localparam logic [23:0] RRF_DOWN_LIM = 24'h0186A0;
  // diode readings in millivolts
  localparam logic [23:0] RRF_DIODE_10V = 24'h002710;
  localparam logic [23:0] RRF_DIODE_5V = 24'h001388;
  // timing
  localparam int RRF_CLK_HZ = 20000000;
  localparam int RRF_SHOW_MS = 1000;
  localparam int RRF_SHOW_CYCLES = RRF_CLK_HZ / 1000 * RRF_SHOW_MS;
  localparam logic [2:0] RRF_NO_RANGE = 3'h7;
  localparam logic [2:0] RRF_RANGE_TOP [0:10] =
    '{3'h4, 3'h4, 3'h3, 3'h1, 3'h6, 3'h6, 3'h0, 3'h0, 3'h0, 3'h0, 3'h0};
  localparam logic [2:0] RRF_EXEMPT_RANGE [0:10] =
    '{3'h4, 3'h4, 3'h3, 3'h1, 3'h5, 3'h5, 3'h7, 3'h7, 3'h7, 3'h7, 3'h7};

  typedef enum logic [3:0] {
    RRF_F_DCV = 4'h0, RRF_F_ACV = 4'h1, RRF_F_DCI = 4'h2, RRF_F_ACI = 4'h3,
    RRF_F_OHM2 = 4'h4, RRF_F_OHM4 = 4'h5, RRF_F_FREQ = 4'h6, RRF_F_PER = 4'h7,
    RRF_F_TEMP = 4'h8, RRF_F_CONTINUITY_CHECK_MODE = 4'h9, RRF_F_DIODE = 4'hA
  } rrf_func_type;

  typedef enum logic [1:0] {
    RRF_RATE_FAST = 2'h0, RRF_RATE_MED = 2'h1, RRF_RATE_SLOW = 2'h2
  } rrf_rate_type;

  typedef enum logic [1:0] {
    RRF_DC_1MA = 2'h0, RRF_DC_100UA = 2'h1, RRF_DC_10UA = 2'h2
  } rrf_dcur_type;

  typedef struct packed {
    logic signed [23:0] value;
  } rrf_conv_type;

  typedef struct packed {
    logic signed [23:0] value;
    logic overflow;
    logic [2:0] range;
    rrf_func_type func;
  } rrf_read_type;
endpackage

/* hw/rrf_filter.sv */
// Implementation choices: the address map and the Wishbone register port.
module rrf_filter #(
  parameter int SHOW_CYCLES = rrf_pkg::RRF_SHOW_CYCLES
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic conv_valid,
  output logic conv_ready,
  input rrf_pkg::rrf_conv_type conv_data,
  output logic rd_valid,
  input wire logic rd_ready,
  output rrf_pkg::rrf_read_type rd_data,
  output logic continuity_check_mode_beep,
  output rrf_pkg::rrf_rate_type rate_sel,
  output rrf_pkg::rrf_dcur_type diode_current,
  output logic auto_indicator,
  output logic averaging_active_indicator,
  output logic range_show,
  output logic [2:0] cur_range
);
  rrf_pkg::rrf_func_type func_reg;
  rrf_pkg::rrf_rate_type user_rate_reg;
  rrf_pkg::rrf_rate_type rate_sel_reg;
  rrf_pkg::rrf_dcur_type dcur_reg;
  logic [15:0] thr_reg;
  logic [2:0] range_mem [0:rrf_pkg::RRF_NFUNC-1];
  logic auto_mem [0:rrf_pkg::RRF_NFUNC-1];
  logic fen_mem [0:rrf_pkg::RRF_NFUNC-1];
  logic ftype_mem [0:rrf_pkg::RRF_NFUNC-1];
  logic [6:0] fcnt_mem [0:rrf_pkg::RRF_NFUNC-1];
  logic signed [23:0] store [0:rrf_pkg::RRF_DEPTH-1];
  logic signed [31:0] sum_reg;
  logic [6:0] fill_reg;
  logic [6:0] wp_reg;
  rrf_pkg::rrf_read_type head_reg;
  rrf_pkg::rrf_read_type tail_reg;
  rrf_pkg::rrf_read_type last_reg;
  logic [1:0] cnt_reg;
  logic rd_valid_reg;
  logic conv_ready_reg;
  logic [24:0] show_cnt_reg;
  logic range_show_reg;
  logic beep_reg;
  logic auto_ind_reg;
  logic avg_ind_reg;
  logic [2:0] cur_range_reg;
  logic [31:0] wb_dat_reg;
  logic wb_ack_reg;

  // bus decode
  wire acc = wb_cyc_i & wb_stb_i & ~wb_ack_reg;
  wire wr = acc & wb_we_i;
  wire hit_func = wb_adr_i == rrf_pkg::RRF_ADR_FUNC;
  wire hit_cmd = wb_adr_i == rrf_pkg::RRF_ADR_CMD;
  wire hit_fcfg = wb_adr_i == rrf_pkg::RRF_ADR_FCFG;
  wire hit_thr = wb_adr_i == rrf_pkg::RRF_ADR_THR;
  wire hit_dcur = wb_adr_i == rrf_pkg::RRF_ADR_DCUR;
  wire hit_stat = wb_adr_i == rrf_pkg::RRF_ADR_STAT;
  wire hit_read = wb_adr_i == rrf_pkg::RRF_ADR_READ;

  // current function view
  wire [3:0] f = func_reg;
  wire [2:0] rng = range_mem[f];
  wire [2:0] top = rrf_pkg::RRF_RANGE_TOP[f];
  wire is_continuity_check_mode = func_reg == rrf_pkg::RRF_F_CONTINUITY_CHECK_MODE;
  wire is_diode = func_reg == rrf_pkg::RRF_F_DIODE;
  wire is_temp = func_reg == rrf_pkg::RRF_F_TEMP;
  wire is_freq = func_reg == rrf_pkg::RRF_F_FREQ;
  wire is_per = func_reg == rrf_pkg::RRF_F_PER;
  wire is_fixed = is_continuity_check_mode | is_diode | is_temp;
  wire flt_allowed = ~(is_continuity_check_mode | is_diode | is_freq | is_per);
  wire auto_on = auto_mem[f] & ~is_fixed;
  wire flt_on = fen_mem[f] & flt_allowed;
  wire [6:0] n = fcnt_mem[f];
  wire ftype = ftype_mem[f];

  // read mux and byte-lane merge
  logic [31:0] rd_value;
  always_comb begin
    rd_value = 32'h0;
    if (hit_func) begin
      rd_value = {22'h0, user_rate_reg, 4'h0, func_reg};
    end else if (hit_fcfg) begin
      rd_value = {23'h0, ftype, 1'b0, n};
    end else if (hit_thr) begin
      rd_value = {16'h0, thr_reg};
    end else if (hit_dcur) begin
      rd_value = {30'h0, dcur_reg};
    end else if (hit_stat) begin
      rd_value = {22'h0, rate_sel_reg, last_reg.overflow, range_show_reg,
                  beep_reg, avg_ind_reg, auto_ind_reg, cur_range_reg};
    end else if (hit_read) begin
      rd_value = last_reg;
    end
  end

  logic [31:0] wd;
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wd[i*8 +: 8] = wb_sel_i[i] ? wb_dat_i[i*8 +: 8] : rd_value[i*8 +: 8];
    end
  end

  // register writes and commands
  wire func_wr = wr & hit_func;
  wire [3:0] new_func = wd[3:0];
  wire func_ok = new_func < 4'(rrf_pkg::RRF_NFUNC);
  wire func_chg = func_wr & func_ok & (new_func != func_reg);
  wire [1:0] new_rate = wd[rrf_pkg::RRF_FUNC_RATE_LSB +: 2];
  wire rate_ok = new_rate != 2'h3;
  wire cmd_up = wr & hit_cmd & wd[rrf_pkg::RRF_CMD_UP];
  wire cmd_dn = wr & hit_cmd & wd[rrf_pkg::RRF_CMD_DOWN];
  wire cmd_auto = wr & hit_cmd & wd[rrf_pkg::RRF_CMD_AUTO] & ~is_fixed;
  wire cmd_averaging_active_indicator = wr & hit_cmd & wd[rrf_pkg::RRF_CMD_AVERAGING_ACTIVE_INDICATOR] & flt_allowed;
  wire [6:0] new_cnt = wd[6:0];
  wire fcfg_wr = wr & hit_fcfg;
  wire cnt_ok = (new_cnt >= rrf_pkg::RRF_FCNT_MIN) && (new_cnt <= rrf_pkg::RRF_FCNT_MAX);
  wire [15:0] new_thr = wd[15:0];
  wire thr_ok = (new_thr >= rrf_pkg::RRF_THR_MIN) && (new_thr <= rrf_pkg::RRF_THR_MAX);
  wire dcur_ok = wd[1:0] != 2'h3;

  // conversion checks
  // conv_ready_reg already says the buffer has room for the word
  wire fire = conv_valid & conv_ready_reg;
  wire signed [23:0] x = conv_data.value;
  // one magnitude serves overflow, autorange and the beep
  wire [23:0] ax = x[23] ? 24'(-x) : x;
  wire exempt = rrf_pkg::RRF_EXEMPT_RANGE[f] == rng;
  wire [23:0] lim = exempt ? rrf_pkg::RRF_FS : rrf_pkg::RRF_UP_LIM;
  wire [23:0] dlim = (dcur_reg == rrf_pkg::RRF_DC_100UA) ? rrf_pkg::RRF_DIODE_5V
                     : rrf_pkg::RRF_DIODE_10V;
  wire ovf = is_diode ? (ax > dlim) : (ax > lim);
  wire man_up = (cmd_up & ~is_fixed) & (rng < top);
  wire man_dn = (cmd_dn & ~is_fixed) & (rng != 3'h0);
  wire man_step = man_up | man_dn;
  // a range key cancels auto even at the range end, where no step happens
  wire man_req = (cmd_up | cmd_dn) & ~is_fixed;
  wire auto_up = fire & auto_on & ~man_step & (ax >= rrf_pkg::RRF_UP_LIM) & (rng < top);
  wire auto_dn = fire & auto_on & ~man_step & (ax <= rrf_pkg::RRF_DOWN_LIM)
                 & (rng != 3'h0);
  wire step = man_step | auto_up | auto_dn;
  wire [2:0] rng_next = (man_up | auto_up) ? 3'(rng + 3'h1)
                        : (man_dn | auto_dn) ? 3'(rng - 3'h1) : rng;
  // stale conversions must not leak into a reading on new settings
  wire cnt_chg = fcfg_wr & cnt_ok;
  wire type_chg = fcfg_wr & (wd[rrf_pkg::RRF_FCFG_TYPE_BIT] != ftype);
  wire clear = func_chg | step | cnt_chg | type_chg | cmd_averaging_active_indicator;

  // averaging
  wire signed [31:0] xs = {{8{x[23]}}, x};
  wire signed [31:0] olds = {{8{store[wp_reg][23]}}, store[wp_reg]};
  wire full = fill_reg == n;
  wire signed [31:0] sum_add = sum_reg + xs;
  wire signed [31:0] sum_mov = full ? (sum_add - olds) : sum_add;
  wire signed [31:0] sum_n = ftype ? sum_add : sum_mov;
  wire [6:0] fill_n = (~ftype & full) ? fill_reg : 7'(fill_reg + 7'h1);
  wire emit = fill_n == n;
  // one divider per reading: area traded for a single-cycle mean
  wire signed [31:0] avg = sum_n / $signed({25'h0, n});
  // a conversion that moves the range is spent on the step, not output
  wire take = fire & ~(auto_up | auto_dn) & ~clear;
  wire feed = take & ~ovf & flt_on;
  wire push = take & (ovf | ~flt_on | emit);
  wire pop = rd_valid_reg & rd_ready;

  rrf_pkg::rrf_read_type res;
  always_comb begin
    res.value = ovf ? 24'sh0 : (flt_on ? avg[23:0] : x);
    res.overflow = ovf;
    res.range = rng;
    res.func = func_reg;
  end

  // occupancy; conv_ready is withheld while both slots are full
  wire [1:0] cnt_next = 2'(cnt_reg + {1'b0, push} - {1'b0, pop});
  // a manual step reloads the timer, so the latest range stays shown
  wire [24:0] show_next = man_step ? 25'(SHOW_CYCLES)
                          : (show_cnt_reg != 25'h0) ? 25'(show_cnt_reg - 25'h1)
                          : 25'h0;
  // fixed-rate functions override the stored choice, which survives
  wire [1:0] eff_rate = is_continuity_check_mode ? rrf_pkg::RRF_RATE_FAST
                        : is_diode ? rrf_pkg::RRF_RATE_MED : user_rate_reg;

  // bus slave: one wait state, unmapped reads return zero
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      wb_ack_reg <= 1'b0;
      wb_dat_reg <= 32'h0;
    end else begin
      wb_ack_reg <= acc;
      wb_dat_reg <= acc ? rd_value : wb_dat_reg;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      func_reg <= rrf_pkg::RRF_F_DCV;
      user_rate_reg <= rrf_pkg::RRF_RATE_MED;
      thr_reg <= rrf_pkg::RRF_THR_RST;
      dcur_reg <= rrf_pkg::RRF_DC_1MA;
    end else begin
      if (func_wr & func_ok) begin
        func_reg <= rrf_pkg::rrf_func_type'(new_func);
      end
      // rate writes are dropped while a fixed-rate function is active
      if (func_wr & rate_ok & ~is_continuity_check_mode & ~is_diode) begin
        user_rate_reg <= rrf_pkg::rrf_rate_type'(new_rate);
      end
      if (wr & hit_thr & thr_ok) begin
        thr_reg <= new_thr;
      end
      if (wr & hit_dcur & dcur_ok) begin
        dcur_reg <= rrf_pkg::rrf_dcur_type'(wd[1:0]);
      end
    end
  end

  // per-function settings, restored simply by indexing with func_reg
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < rrf_pkg::RRF_NFUNC; i++) begin
        range_mem[i] <= 3'h0;
        auto_mem[i] <= 1'b0;
        fen_mem[i] <= 1'b0;
        ftype_mem[i] <= 1'b0;
        fcnt_mem[i] <= rrf_pkg::RRF_FCNT_RST;
      end
    end else begin
      range_mem[f] <= rng_next;
      if (man_req) begin
        auto_mem[f] <= 1'b0;
      end else if (cmd_auto) begin
        auto_mem[f] <= ~auto_mem[f];
      end
      if (cmd_averaging_active_indicator) begin
        fen_mem[f] <= ~fen_mem[f];
      end
      if (fcfg_wr) begin
        ftype_mem[f] <= wd[rrf_pkg::RRF_FCFG_TYPE_BIT];
      end
      if (fcfg_wr & cnt_ok) begin
        fcnt_mem[f] <= new_cnt;
      end
    end
  end

  // no reset on the store: fill_reg says which words are live
  always_ff @(posedge clk_sys) begin
    if (feed) begin
      store[wp_reg] <= x;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      sum_reg <= 32'sh0;
      fill_reg <= 7'h0;
      wp_reg <= 7'h0;
    end else if (clear) begin
      sum_reg <= 32'sh0;
      fill_reg <= 7'h0;
      wp_reg <= 7'h0;
    end else if (feed & ftype & emit) begin
      // group done: start empty so no conversion is reused
      sum_reg <= 32'sh0;
      fill_reg <= 7'h0;
      wp_reg <= 7'h0;
    end else if (feed) begin
      sum_reg <= sum_n;
      fill_reg <= fill_n;
      wp_reg <= (wp_reg == 7'(n - 7'h1)) ? 7'h0 : 7'(wp_reg + 7'h1);
    end
  end

  // two-entry output buffer; head is always the oldest word
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      head_reg <= '0;
      tail_reg <= '0;
      cnt_reg <= 2'h0;
      rd_valid_reg <= 1'b0;
      conv_ready_reg <= 1'b0;
    end else begin
      if (pop & (cnt_reg == 2'h2)) begin
        head_reg <= tail_reg;
      end else if (push & ((cnt_reg == 2'h0) | (pop & (cnt_reg == 2'h1)))) begin
        head_reg <= res;
      end
      if (push & ((cnt_reg == 2'h1 & ~pop) | (cnt_reg == 2'h2))) begin
        tail_reg <= res;
      end
      cnt_reg <= cnt_next;
      rd_valid_reg <= cnt_next != 2'h0;
      conv_ready_reg <= cnt_next != 2'h2;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      last_reg <= '0;
      show_cnt_reg <= 25'h0;
      range_show_reg <= 1'b0;
      beep_reg <= 1'b0;
    end else begin
      if (push) begin
        last_reg <= res;
      end
      show_cnt_reg <= show_next;
      range_show_reg <= show_next != 25'h0;
      if (~is_continuity_check_mode) begin
        beep_reg <= 1'b0;
      end else if (fire) begin
        // negative readings beep too; a short reads near zero either way
        beep_reg <= ~ovf & ((x < 24'sh0) | (ax < {8'h0, thr_reg}));
      end
    end
  end

  // indicators follow the selected function one cycle later
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rate_sel_reg <= rrf_pkg::RRF_RATE_MED;
      auto_ind_reg <= 1'b0;
      avg_ind_reg <= 1'b0;
      cur_range_reg <= 3'h0;
    end else begin
      rate_sel_reg <= rrf_pkg::rrf_rate_type'(eff_rate);
      auto_ind_reg <= auto_on;
      avg_ind_reg <= flt_on;
      cur_range_reg <= rng;
    end
  end

  assign wb_ack_o = wb_ack_reg;
  assign wb_dat_o = wb_dat_reg;
  assign conv_ready = conv_ready_reg;
  assign rd_valid = rd_valid_reg;
  assign rd_data = head_reg;
  assign continuity_check_mode_beep = beep_reg;
  assign rate_sel = rate_sel_reg;
  assign diode_current = dcur_reg;
  assign auto_indicator = auto_ind_reg;
  assign averaging_active_indicator = avg_ind_reg;
  assign range_show = range_show_reg;
  assign cur_range = cur_range_reg;
endmodule

/* sim/rrf_filter_properties.sv */
module rrf_filter_properties #(
  parameter int SHOW_CYCLES = 20
) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic rd_valid,
  input rrf_pkg::rrf_read_type rd_data,
  input rrf_pkg::rrf_rate_type rate_sel,
  input rrf_pkg::rrf_dcur_type diode_current,
  input wire logic auto_indicator,
  input wire logic averaging_active_indicator,
  input wire logic range_show,
  input wire logic [2:0] cur_range
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  logic [31:0] show_cnt_reg;
  wire logic [31:0] show_cnt_next = range_show ? show_cnt_reg + 32'h1 : 32'h0;
  wire rrf_pkg::rrf_func_type fn = rd_data.func;
  wire logic signed [31:0] val = {{8{rd_data.value[23]}}, rd_data.value};
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      show_cnt_reg <= 32'h0;
    end else begin
      show_cnt_reg <= show_cnt_next;
    end
  end
  a_continuity_check_mode_rate_fast: assert property (rd_valid && fn == rrf_pkg::RRF_F_CONTINUITY_CHECK_MODE |->
    rate_sel == rrf_pkg::RRF_RATE_FAST) else $error("continuity rate not fast");
  a_diode_rate_med: assert property (rd_valid && fn == rrf_pkg::RRF_F_DIODE |->
    rate_sel == rrf_pkg::RRF_RATE_MED) else $error("diode rate not medium");
  a_diode_volt_limit: assert property (rd_valid && fn == rrf_pkg::RRF_F_DIODE &&
    !rd_data.overflow |-> val <= (diode_current == rrf_pkg::RRF_DC_100UA ? 5000 : 10000))
    else $error("diode reading above limit");
  a_overflow_no_value: assert property (rd_valid && rd_data.overflow |->
    rd_data.value == 24'h0) else $error("overflow word carries a value");
  a_reading_in_scale: assert property (rd_valid && !rd_data.overflow &&
    fn != rrf_pkg::RRF_F_DIODE |-> val <= 1200000 && val >= -1200000)
    else $error("reading beyond overrange");
  a_step_by_one: assert property ($rose(range_show) |=>
    cur_range == $past(cur_range, 2) + 3'h1 || cur_range == $past(cur_range, 2) - 3'h1)
    else $error("manual step not one range");
  a_show_duration: assert property ($fell(range_show) |-> show_cnt_reg == SHOW_CYCLES)
    else $error("range display time wrong");
  a_step_cancels_auto: assert property ($rose(range_show) |=> !auto_indicator)
    else $error("manual step left auto on");
  a_auto_blocked: assert property (rd_valid && fn inside {rrf_pkg::RRF_F_TEMP,
    rrf_pkg::RRF_F_CONTINUITY_CHECK_MODE, rrf_pkg::RRF_F_DIODE} |-> !auto_indicator && rd_data.range == 3'h0)
    else $error("auto or range in fixed function");
  a_filter_blocked: assert property (rd_valid && fn inside {rrf_pkg::RRF_F_FREQ,
    rrf_pkg::RRF_F_PER, rrf_pkg::RRF_F_CONTINUITY_CHECK_MODE, rrf_pkg::RRF_F_DIODE} |->
    !averaging_active_indicator) else $error("filter active where barred");
endmodule

bind rrf_filter rrf_filter_properties #(.SHOW_CYCLES(SHOW_CYCLES)) rrf_filter_properties_inst (
  .clk_sys(clk_sys),
  .rst_n(rst_n),
  .rd_valid(rd_valid),
  .rd_data(rd_data),
  .rate_sel(rate_sel),
  .diode_current(diode_current),
  .auto_indicator(auto_indicator),
  .averaging_active_indicator(averaging_active_indicator),
  .range_show(range_show),
  .cur_range(cur_range)
);

/* sim/rrf_conv_model.sv */
module rrf_conv_model (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic conv_ready,
  input wire logic slow,
  output logic conv_valid,
  output rrf_pkg::rrf_conv_type conv_data
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [23:0] pend_q[$];
  logic [1:0] gap_reg;
  always @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      conv_valid <= 1'b0;
      conv_data <= '0;
      gap_reg <= 2'h0;
    end else if (conv_valid && conv_ready) begin
      conv_valid <= 1'b0;
      // released lines must not keep showing the taken word
      conv_data <= ~conv_data;
      gap_reg <= slow ? 2'h3 : 2'h0;
    end else if (gap_reg != 2'h0) begin
      gap_reg <= gap_reg - 2'h1;
    end else if (!conv_valid && pend_q.size() > 0) begin
      conv_valid <= 1'b1;
      conv_data.value <= pend_q.pop_front();
    end
  end
endmodule

/* sim/rrf_filter_test.sv */
module rrf_filter_test;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int SHOW = 20;
  logic clk_sys = 1'b0;
  logic rst_n = 1'b0;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [7:0] wb_adr_i = 8'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, conv_valid, conv_ready, rd_valid, continuity_check_mode_beep, auto_indicator, range_show;
  logic averaging_active_indicator, rd_ready = 1'b0, slow = 1'b0, stall = 1'b0;
  logic [2:0] cur_range;
  rrf_pkg::rrf_conv_type conv_data;
  rrf_pkg::rrf_read_type rd_data;
  rrf_pkg::rrf_rate_type rate_sel;
  rrf_pkg::rrf_dcur_type diode_current;
  int errors = 0, num_checks = 0, seed = 32'h8133, fn = 0, rg = 0, lim;
  logic [31:0] exp_q[$], rdat;
  int tv[4] = '{32'h3E8, 32'h3E9, 32'h0, 32'h1};
  int te[4] = '{32'h3E8, 32'h3E8, 32'h3E8, 32'h1};

  rrf_filter #(.SHOW_CYCLES(SHOW)) rrf_filter_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(4'hF), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .conv_valid(conv_valid), .conv_ready(conv_ready), .conv_data(conv_data),
    .rd_valid(rd_valid), .rd_ready(rd_ready), .rd_data(rd_data), .continuity_check_mode_beep(continuity_check_mode_beep),
    .rate_sel(rate_sel), .diode_current(diode_current), .auto_indicator(auto_indicator),
    .averaging_active_indicator(averaging_active_indicator), .range_show(range_show),
    .cur_range(cur_range));
  rrf_conv_model rrf_conv_model_inst (.clk_sys(clk_sys), .rst_n(rst_n),
    .conv_ready(conv_ready), .slow(slow), .conv_valid(conv_valid), .conv_data(conv_data));

  always #25 clk_sys = ~clk_sys;

  task check(input logic [31:0] seen, input logic [31:0] expect_v);
    num_checks++;
    if (seen !== expect_v) begin
      errors++;
      $display("ERROR %0t: seen %h expected %h", $time, seen, expect_v);
    end
  endtask

  task report_and_stop;
    if (errors == 0 && num_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task wb(input logic we, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= d;
    do begin
      @(posedge clk_sys);
    end while (wb_ack_o !== 1'b1);
    rdat = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask

  function automatic logic [31:0] word(input int v, input logic ovf, input int r, input int f);
    return {v[23:0], ovf, r[2:0], f[3:0]};
  endfunction

  task put(input int v, input int ev, input logic ovf);
    rrf_conv_model_inst.pend_q.push_back(v[23:0]);
    exp_q.push_back(word(ev, ovf, rg, fn));
  endtask

  task settle;
    int n;
    n = 0;
    while ((exp_q.size() > 0 || rrf_conv_model_inst.pend_q.size() > 0 || conv_valid)
           && n < 5000) begin
      @(posedge clk_sys);
      n++;
    end
    if (n >= 5000) errors++;
    repeat (4) @(posedge clk_sys);
  endtask

  task step(input int up);
    wb(1'b1, rrf_pkg::RRF_ADR_CMD, up ? 32'h1 : 32'h2);
    rg = up ? rg + 1 : rg - 1;
    check(32'(cur_range), rg);
    check(32'({range_show, auto_indicator}), 32'h2);
    repeat (SHOW + 10) @(posedge clk_sys);
  endtask

  // moving and repeating share one mean; only the emit condition differs
  task run_filter(input int n, input int typ);
    int v[$];
    longint s;
    wb(1'b1, rrf_pkg::RRF_ADR_FCFG, 32'((typ << 8) | n));
    for (int i = 0; i < (typ ? 2 * n : n + 2); i++) begin
      v.push_back($random(seed) % 900000);
      rrf_conv_model_inst.pend_q.push_back(v[i][23:0]);
      if ((typ == 0 && i >= n - 1) || (typ == 1 && (i + 1) % n == 0)) begin
        s = 0;
        for (int j = i - n + 1; j <= i; j++) s += v[j];
        exp_q.push_back(word(int'(s / n), 1'b0, rg, fn));
      end
    end
    settle;
  endtask

  always @(posedge clk_sys) begin
    if (rd_valid === 1'b1 && rd_ready === 1'b1)
      check(rd_data, exp_q.size() > 0 ? exp_q.pop_front() : 32'hFFFFFFFF);
    rd_ready <= stall ? 1'b0 : ($random(seed) % 4 != 0);
  end

  initial begin
    #4000000;
    errors++;
    report_and_stop;
  end

  initial begin
    repeat (2) @(posedge clk_sys);
    rst_n <= 1'b1;
    @(posedge clk_sys);
    check(32'(rate_sel), 32'h1);
    wb(1'b0, rrf_pkg::RRF_ADR_THR, 32'h0);
    check(rdat, 32'hA);
    wb(1'b0, 8'hFC, 32'h0);
    check(rdat, 32'h0);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, rrf_pkg::RRF_ADR_THR, tv[i]);
      wb(1'b0, rrf_pkg::RRF_ADR_THR, 32'h0);
      check(rdat, te[i]);
    end
    repeat (8) begin
      lim = $random(seed) % 1000000;
      put(lim, lim, 1'b0);
    end
    put(32'h124F80, 32'h124F80, 1'b0);
    put(32'h124F81, 32'h0, 1'b1);
    put(-32'sh124F81, 32'h0, 1'b1);
    settle;
    wb(1'b1, rrf_pkg::RRF_ADR_CMD, 32'h4);
    rrf_conv_model_inst.pend_q.push_back(24'h124F80);
    settle;
    rg = 1;
    check(32'({cur_range, auto_indicator}), 32'h3);
    put(32'h186A1, 32'h186A1, 1'b0);
    rrf_conv_model_inst.pend_q.push_back(24'h0186A0);
    rrf_conv_model_inst.pend_q.push_back(24'h124F80);
    settle;
    wb(1'b1, rrf_pkg::RRF_ADR_CMD, 32'h4);
    check(32'({cur_range, auto_indicator}), 32'h2);
    step(0);
    wb(1'b1, rrf_pkg::RRF_ADR_CMD, 32'h4);
    repeat (4) step(1);
    put(32'hF4240, 32'hF4240, 1'b0);
    put(32'hF4241, 32'h0, 1'b1);
    settle;
    wb(1'b1, rrf_pkg::RRF_ADR_FUNC, 32'h1);
    check(32'(cur_range), 32'h0);
    wb(1'b1, rrf_pkg::RRF_ADR_CMD, 32'h8);
    wb(1'b1, rrf_pkg::RRF_ADR_FUNC, 32'h0);
    check(32'({cur_range, averaging_active_indicator}), 32'h8);
    wb(1'b1, rrf_pkg::RRF_ADR_CMD, 32'h8);
    check(32'(averaging_active_indicator), 32'h1);
    run_filter(4, 0);
    run_filter(3, 1);
    run_filter(100, 1);
    run_filter(1, 0);
    wb(1'b1, rrf_pkg::RRF_ADR_FCFG, 32'h65);
    wb(1'b0, rrf_pkg::RRF_ADR_FCFG, 32'h0);
    check(rdat, 32'h1);
    wb(1'b1, rrf_pkg::RRF_ADR_FUNC, 32'h6);
    fn = 6;
    rg = 0;
    wb(1'b1, rrf_pkg::RRF_ADR_CMD, 32'h8);
    check(32'(averaging_active_indicator), 32'h0);
    stall = 1'b1;
    slow = 1'b1;
    for (int i = 1; i < 5; i++) put(i * 32'h3E8, i * 32'h3E8, 1'b0);
    repeat (30) @(posedge clk_sys);
    check(32'(conv_ready), 32'h0);
    stall = 1'b0;
    settle;
    wb(1'b1, rrf_pkg::RRF_ADR_FUNC, 32'h209);
    fn = 9;
    wb(1'b1, rrf_pkg::RRF_ADR_CMD, 32'h4);
    wb(1'b1, rrf_pkg::RRF_ADR_THR, 32'hA);
    wb(1'b1, rrf_pkg::RRF_ADR_FUNC, 32'h109);
    wb(1'b0, rrf_pkg::RRF_ADR_FUNC, 32'h0);
    check(rdat, 32'h209);
    check(32'({rate_sel, auto_indicator}), 32'h0);
    put(32'h9, 32'h9, 1'b0);
    settle;
    check(32'(continuity_check_mode_beep), 32'h1);
    put(32'hA, 32'hA, 1'b0);
    settle;
    check(32'(continuity_check_mode_beep), 32'h0);
    wb(1'b1, rrf_pkg::RRF_ADR_FUNC, 32'hA);
    fn = 10;
    check(32'(rate_sel), 32'h1);
    for (int i = 0; i < 4; i++) begin
      wb(1'b1, rrf_pkg::RRF_ADR_DCUR, 32'(i));
      check(32'(diode_current), i < 3 ? i : 2);
      lim = (i == 1) ? 32'h1388 : 32'h2710;
      put(lim, lim, 1'b0);
      put(lim + 1, 32'h0, 1'b1);
      settle;
    end
    report_and_stop;
  end
endmodule
